// [hdl/itv_cmd.sv]
// command interpreter for interval settings and simulation commands
`timescale 1ns/10ps
`default_nettype none
`include "itv_defs.svh"
module itv_cmd #(
  parameter int FIFO_DEPTH = `ITV_FIFO_DEPTH,
  parameter int TICK_HZ = `ITV_TICK_HZ
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic cts,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  input wire logic [39:0] meas_count_bcd,
  input wire logic [39:0] meas_freq_bcd,
  input wire logic [39:0] meas_temp_adc_bcd,
  output logic sim_load,
  output logic [39:0] sim_count_bcd,
  output logic [39:0] sim_freq_bcd,
  output logic [39:0] sim_temp_adc_bcd,
  input wire logic calc_valid,
  input wire logic calc_mpsas_neg,
  input wire logic [15:0] calc_mpsas_bcd,
  input wire logic [39:0] calc_period_bcd,
  input wire logic calc_temp_neg,
  input wire logic [15:0] calc_temp_bcd,
  output logic [39:0] period_ram_bcd,
  output logic [39:0] period_nv_bcd,
  output logic [39:0] thresh_ram_bcd,
  output logic [39:0] thresh_nv_bcd
);
  import itv_pkg::*;

  if (TICK_HZ <= 0 || FIFO_DEPTH < 2) begin : g_bad_param
    $error("itv_cmd: TICK_HZ must be positive and FIFO_DEPTH at least 2");
  end

  // ****************************************
  // ascii field builders
  // ****************************************
  function automatic logic [79:0] asc(input logic [39:0] d);
    logic [79:0] a;
    a = '0;
    for (int i = 0; i < `ITV_FIELD_DIGITS; i++) begin
      a[i*8 +: 8] = {4'h3, d[i*4 +: 4]};
    end
    return a;
  endfunction

  function automatic logic [7:0] sgn(input logic neg);
    return neg ? 8'h2D : 8'h20;
  endfunction

  // ****************************************
  // state
  // ****************************************
  itv_state_type state_r, state_nxt;
  itv_msg_type kind_r, kind_nxt;
  logic [7:0] cmd_r, cmd_nxt;
  logic [1:0] fidx_r, fidx_nxt;
  logic seen_r, seen_nxt;
  logic [39:0] acc_r, acc_nxt;
  logic [39:0] per_nv_r, per_nv_nxt, per_ram_r, per_ram_nxt;
  logic [39:0] thr_nv_r, thr_nv_nxt, thr_ram_r, thr_ram_nxt;
  logic [39:0] sc_r, sc_nxt, sf_r, sf_nxt, st_r, st_nxt;
  logic [6:0] col_r, col_nxt;
  logic load_r, load_nxt;

  logic take, is_digit, fifo_ready, send_ok;
  logic [6:0] last_col;
  logic [8*`ITV_MSG_BYTES-1:0] msg;
  logic [7:0] msg_byte;
  logic [79:0] a_pnv, a_pram, a_tnv, a_tram, a_c, a_f, a_t, a_sc, a_sf, a_st;
  logic [79:0] a_mp, a_per, a_tc;

  assign cts = (state_r == ITV_ST_IDLE) || (state_r == ITV_ST_ARGS);
  assign take = rx_valid && cts;
  assign is_digit = (rx_data >= `ITV_DIGIT_LO) && (rx_data <= `ITV_DIGIT_HI);

  // ****************************************
  // response lines
  // ****************************************
  assign a_pnv = asc(per_nv_r);
  assign a_pram = asc(per_ram_r);
  assign a_tnv = asc(thr_nv_r);
  assign a_tram = asc(thr_ram_r);
  assign a_c = asc(meas_count_bcd);
  assign a_f = asc(meas_freq_bcd);
  assign a_t = asc(meas_temp_adc_bcd);
  assign a_sc = asc(sc_r);
  assign a_sf = asc(sf_r);
  assign a_st = asc(st_r);
  assign a_mp = asc({24'h000000, calc_mpsas_bcd});
  assign a_per = asc(calc_period_bcd);
  assign a_tc = asc({24'h000000, calc_temp_bcd});

  always_comb begin
    msg = '0;
    last_col = `ITV_LEN_INTERVAL - 7'h01;
    case (kind_r)
      ITV_MSG_INTERVAL: begin
        msg = {"I,", a_pnv, "s,", a_pram, "s,",
          a_tnv[79:16], ".", a_tnv[15:0], "m,",
          a_tram[79:16], ".", a_tram[15:0], "m",
          `ITV_CR, `ITV_LF, {42{8'h00}}};
        last_col = `ITV_LEN_INTERVAL - 7'h01;
      end
      ITV_MSG_INTERNAL: begin
        msg = {"s,", a_c, "c,", a_f, "f,", a_t, "t,",
          `ITV_CR, `ITV_LF, {55{8'h00}}};
        last_col = `ITV_LEN_INTERNAL - 7'h01;
      end
      ITV_MSG_SIM: begin
        msg = {"S,", a_sc, "c,", a_sf, "f,", a_st, "t,",
          "r,", sgn(calc_mpsas_neg), a_mp[31:16], ".", a_mp[15:0], "m,",
          a_sf, "Hz,", a_sc, "c,",
          a_per[79:24], ".", a_per[23:0], "s,",
          sgn(calc_temp_neg), a_tc[31:8], ".", a_tc[7:0], "C",
          `ITV_CR, `ITV_LF};
        last_col = `ITV_LEN_SIM - 7'h01;
      end
      default: begin
        msg = '0;
        last_col = `ITV_LEN_INTERVAL - 7'h01;
      end
    endcase
  end

  assign msg_byte = msg[(`ITV_MSG_BYTES - 1 - int'(col_r)) * 8 +: 8];
  assign send_ok = (state_r == ITV_ST_SEND) && fifo_ready;

  // ****************************************
  // command parser and sequencer
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    kind_nxt = kind_r;
    cmd_nxt = cmd_r;
    fidx_nxt = fidx_r;
    seen_nxt = seen_r;
    acc_nxt = acc_r;
    per_nv_nxt = per_nv_r;
    per_ram_nxt = per_ram_r;
    thr_nv_nxt = thr_nv_r;
    thr_ram_nxt = thr_ram_r;
    sc_nxt = sc_r;
    sf_nxt = sf_r;
    st_nxt = st_r;
    col_nxt = col_r;
    load_nxt = 1'b0;
    case (state_r)
      ITV_ST_IDLE: begin
        if (take && rx_data != `ITV_TERM) begin
          cmd_nxt = rx_data;
          fidx_nxt = 2'b00;
          seen_nxt = 1'b0;
          acc_nxt = '0;
          state_nxt = ITV_ST_ARGS;
          if (rx_data == `ITV_CMD_SIM_SET) begin
            sc_nxt = '0;
            sf_nxt = '0;
            st_nxt = '0;
          end
        end
      end
      ITV_ST_ARGS: begin
        if (take && rx_data == `ITV_TERM) begin
          state_nxt = ITV_ST_SEND;
          col_nxt = '0;
          case (cmd_r)
            `ITV_CMD_INTERVAL: kind_nxt = ITV_MSG_INTERVAL;
            `ITV_CMD_INTERNAL: kind_nxt = ITV_MSG_INTERNAL;
            `ITV_CMD_PER_NV: begin
              per_nv_nxt = acc_r;
              per_ram_nxt = acc_r;
              kind_nxt = ITV_MSG_INTERVAL;
            end
            `ITV_CMD_PER_RAM: begin
              per_ram_nxt = acc_r;
              kind_nxt = ITV_MSG_INTERVAL;
            end
            `ITV_CMD_THR_NV: begin
              thr_nv_nxt = acc_r;
              thr_ram_nxt = acc_r;
              kind_nxt = ITV_MSG_INTERVAL;
            end
            `ITV_CMD_THR_RAM: begin
              thr_ram_nxt = acc_r;
              kind_nxt = ITV_MSG_INTERVAL;
            end
            `ITV_CMD_SIM_SET: begin
              kind_nxt = ITV_MSG_SIM;
              load_nxt = 1'b1;
              state_nxt = ITV_ST_CALC;
            end
            default: state_nxt = ITV_ST_IDLE;
          endcase
        end else if (take && is_digit) begin
          seen_nxt = 1'b1;
          acc_nxt = {acc_r[35:0], rx_data[3:0]};
          if (cmd_r == `ITV_CMD_SIM_SET) begin
            case (fidx_r)
              2'b00: sc_nxt = {sc_r[35:0], rx_data[3:0]};
              2'b01: sf_nxt = {sf_r[35:0], rx_data[3:0]};
              default: st_nxt = {st_r[35:0], rx_data[3:0]};
            endcase
          end
        end else if (take && seen_r && fidx_r != 2'b10) begin
          // any other byte closes a started first or second sim field; the third stays open
          fidx_nxt = fidx_r + 2'b01;
          seen_nxt = 1'b0;
        end
      end
      ITV_ST_CALC: begin
        if (calc_valid) begin
          state_nxt = ITV_ST_SEND;
        end
      end
      ITV_ST_SEND: begin
        if (fifo_ready) begin
          col_nxt = col_r + 7'h01;
          if (col_r == last_col) begin
            state_nxt = ITV_ST_IDLE;
          end
        end
      end
      default: state_nxt = ITV_ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ITV_ST_IDLE;
      kind_r <= ITV_MSG_INTERVAL;
      cmd_r <= 8'h00;
      fidx_r <= 2'b00;
      seen_r <= 1'b0;
      acc_r <= '0;
      per_nv_r <= `ITV_PERIOD_RST;
      per_ram_r <= `ITV_PERIOD_RST;
      thr_nv_r <= `ITV_THRESH_RST;
      thr_ram_r <= `ITV_THRESH_RST;
      sc_r <= '0;
      sf_r <= '0;
      st_r <= '0;
      col_r <= 7'h00;
      load_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      kind_r <= kind_nxt;
      cmd_r <= cmd_nxt;
      fidx_r <= fidx_nxt;
      seen_r <= seen_nxt;
      acc_r <= acc_nxt;
      per_nv_r <= per_nv_nxt;
      per_ram_r <= per_ram_nxt;
      thr_nv_r <= thr_nv_nxt;
      thr_ram_r <= thr_ram_nxt;
      sc_r <= sc_nxt;
      sf_r <= sf_nxt;
      st_r <= st_nxt;
      col_r <= col_nxt;
      load_r <= load_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign sim_load = load_r;
  assign sim_count_bcd = sc_r;
  assign sim_freq_bcd = sf_r;
  assign sim_temp_adc_bcd = st_r;
  assign period_ram_bcd = per_ram_r;
  assign period_nv_bcd = per_nv_r;
  assign thresh_ram_bcd = thr_ram_r;
  assign thresh_nv_bcd = thr_nv_r;

  // response bytes queue up here; a stalled link holds the sequencer
  itv_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .in_valid(state_r == ITV_ST_SEND),
    .in_ready(fifo_ready),
    .in_data(msg_byte),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(tx_data)
  );

  logic unused_ok;
  assign unused_ok = send_ok;
endmodule
`default_nettype wire

// [hdl/itv_fifo.sv]
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module itv_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("itv_fifo: DEPTH must be a power of two >= 2 and WIDTH >= 1");
  end
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [AW:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic push, pop;
  assign in_ready = (wr_r - rd_r) != (AW+1)'(DEPTH);
  assign out_valid = wr_r != rd_r;
  assign out_data = mem_r[rd_r[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_comb begin
    mem_nxt = mem_r;
    wr_nxt = wr_r;
    rd_nxt = rd_r;
    if (push) begin
      mem_nxt[wr_r[AW-1:0]] = in_data;
      wr_nxt = wr_r + 1'b1;
    end
    if (pop) begin
      rd_nxt = rd_r + 1'b1;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_r <= '0;
      rd_r <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      mem_r <= mem_nxt;
    end
  end
endmodule
`default_nettype wire

// [shared/itv_defs.svh]
// constants for the interval and simulation command interpreter
`ifndef ITV_DEFS_SVH
`define ITV_DEFS_SVH
`define ITV_CR 8'h0D
`define ITV_LF 8'h0A
`define ITV_TERM 8'h78
`define ITV_DIGIT_LO 8'h30
`define ITV_DIGIT_HI 8'h39
`define ITV_CMD_INTERVAL 8'h49
`define ITV_CMD_PER_NV 8'h50
`define ITV_CMD_PER_RAM 8'h70
`define ITV_CMD_THR_NV 8'h54
`define ITV_CMD_THR_RAM 8'h74
`define ITV_CMD_SIM_SET 8'h53
`define ITV_CMD_INTERNAL 8'h73
`define ITV_FIELD_DIGITS 10
`define ITV_MSG_BYTES 95
`define ITV_LEN_INTERVAL 7'h35
`define ITV_LEN_INTERNAL 7'h28
`define ITV_LEN_SIM 7'h5F
`define ITV_PERIOD_RST 40'h0000000000
`define ITV_THRESH_RST 40'h0000000000
`define ITV_TICK_HZ 460800
`define ITV_FIFO_DEPTH 16
`endif

// [shared/itv_pkg.sv]
// types for the interval and simulation command interpreter
`default_nettype none
package itv_pkg;
  typedef enum logic [1:0] {
    ITV_ST_IDLE = 2'b00,
    ITV_ST_ARGS = 2'b01,
    ITV_ST_CALC = 2'b10,
    ITV_ST_SEND = 2'b11
  } itv_state_type;
  typedef enum logic [1:0] {
    ITV_MSG_INTERVAL = 2'b00,
    ITV_MSG_INTERNAL = 2'b01,
    ITV_MSG_SIM = 2'b10
  } itv_msg_type;
endpackage
`default_nettype wire

// [testbench/itv_cmd_sva.sv]
// port checker for the command interpreter
`timescale 1ns/10ps
`default_nettype none
module itv_cmd_chk (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic cts,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic sim_load,
  input wire logic calc_valid,
  input wire logic [39:0] period_ram_bcd,
  input wire logic [39:0] period_nv_bcd,
  input wire logic [39:0] thresh_ram_bcd,
  input wire logic [39:0] thresh_nv_bcd
);
  logic armed_r;
  logic armed_nxt;
  logic wait_r;
  logic wait_nxt;
  logic [7:0] letter_r;
  logic [7:0] letter_nxt;
  wire logic take = rx_valid && cts;
  // armed while a command letter has been taken and no terminator yet
  always_comb begin
    armed_nxt = take ? (rx_data != 8'h78) : armed_r;
    letter_nxt = (take && !armed_r && rx_data != 8'h78) ? rx_data : letter_r;
    wait_nxt = sim_load ? 1'h1 : (calc_valid ? 1'h0 : wait_r);
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      armed_r <= 1'h0;
      wait_r <= 1'h0;
      letter_r <= 8'h00;
    end else begin
      armed_r <= armed_nxt;
      wait_r <= wait_nxt;
      letter_r <= letter_nxt;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  property p_cts_drop;
    armed_r && take && rx_data == 8'h78 |=>
      cts == !(letter_r inside {8'h49, 8'h50, 8'h70, 8'h54, 8'h74, 8'h53, 8'h73});
  endproperty
  a_cts_drop: assert property (p_cts_drop) else $error("cts still high after terminator");
  property p_tx_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("reply byte not held");
  property p_load_pulse;
    sim_load |=> !sim_load;
  endproperty
  a_load_pulse: assert property (p_load_pulse) else $error("sim load longer than one cycle");
  property p_load_cause;
    sim_load |-> $past(take && rx_data == 8'h78) && !cts;
  endproperty
  a_load_cause: assert property (p_load_cause) else $error("sim load without terminator");
  property p_per_both;
    $changed(period_nv_bcd) |-> period_nv_bcd == period_ram_bcd;
  endproperty
  a_per_both: assert property (p_per_both) else $error("stored period without active copy");
  property p_thr_both;
    $changed(thresh_nv_bcd) |-> thresh_nv_bcd == thresh_ram_bcd;
  endproperty
  a_thr_both: assert property (p_thr_both) else $error("stored threshold without active copy");
  property p_ascii;
    tx_valid |-> (tx_data >= 8'h20 && tx_data <= 8'h7E) || tx_data == 8'h0D || tx_data == 8'h0A;
  endproperty
  a_ascii: assert property (p_ascii) else $error("non text reply byte");
  property p_calc_wait;
    wait_r && !calc_valid && !tx_valid |=> !tx_valid;
  endproperty
  a_calc_wait: assert property (p_calc_wait) else $error("sim reply before results");
  c_load: cover property (sim_load);
  c_stall: cover property (tx_valid && !tx_ready);
  c_per: cover property ($changed(period_nv_bcd));
endmodule
bind itv_cmd itv_cmd_chk u_itv_cmd_chk (.*);
`default_nettype wire

// [testbench/itv_cmd_tb.sv]
// self-checking bench for the command interpreter
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin failures++; \
  $display("MISMATCH %s exp %h got %h", n, e, a); end end
module itv_cmd_tb;
  import itv_pkg::*;
  logic ref_clk, rst_b, rx_valid, cts, tx_valid, tx_ready, sim_load;
  logic calc_valid, calc_mpsas_neg, calc_temp_neg;
  logic [7:0] rx_data, tx_data;
  logic [15:0] calc_mpsas_bcd, calc_temp_bcd;
  logic [39:0] meas_count_bcd, meas_freq_bcd, meas_temp_adc_bcd, calc_period_bcd;
  logic [39:0] sim_count_bcd, sim_freq_bcd, sim_temp_adc_bcd;
  logic [39:0] period_ram_bcd, period_nv_bcd, thresh_ram_bcd, thresh_nv_bcd;
  logic [39:0] pn, pr, tn, tr;
  int failures = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n;
  string cl[4] = '{"P0000000360x", "p123x", "T17.60x", "t16.00x"};
  logic [39:0] vl[4] = '{40'h360, 40'h123, 40'h1760, 40'h1600};
  itv_cmd u_itv_cmd (.*);
  itv_host u_itv_host (.*);
  initial begin
    ref_clk = 1'h0;
    forever #4 ref_clk = ~ref_clk;
  end
  task complete_run;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      complete_run();
    end
  end
  function automatic string ival();
    return $sformatf("I,%hs,%hs,%h.%hm,%h.%hm\r\n", pn, pr, tn[39:8], tn[7:0], tr[39:8], tr[7:0]);
  endfunction
  // ************************************************
  // collect a reply line, count stray extra bytes as a length mismatch
  // ************************************************
  task expect_line(input string s);
    n = 0;
    while (u_itv_host.rxq.size() < s.len() && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
    repeat (20) @(posedge ref_clk);
    `CHK("length", s.len(), u_itv_host.rxq.size())
    foreach (s[i]) begin
      if (i < u_itv_host.rxq.size()) `CHK("reply byte", s[i], u_itv_host.rxq[i])
    end
    u_itv_host.rxq.delete();
  endtask
  initial begin
    rst_b = 1'h0;
    meas_count_bcd = 40'h360;
    meas_freq_bcd = 40'h360;
    meas_temp_adc_bcd = 40'h244;
    calc_valid = 1'h0;
    calc_mpsas_neg = 1'h0;
    calc_mpsas_bcd = 16'h1804;
    calc_period_bcd = 40'h204;
    calc_temp_neg = 1'h1;
    calc_temp_bcd = 16'h0290;
    {pn, pr, tn, tr} = '0;
    repeat (10) @(posedge ref_clk);
    `CHK("cts", 1'h1, cts)
    rst_b <= 1'h1;
    u_itv_host.send("Ix");
    expect_line(ival());
    for (int i = 0; i < 4; i++) begin
      u_itv_host.send(cl[i]);
      case (cl[i][0])
        "P": {pn, pr} = {vl[i], vl[i]};
        "p": pr = vl[i];
        "T": {tn, tr} = {vl[i], vl[i]};
        default: tr = vl[i];
      endcase
      expect_line(ival());
      `CHK("period_nv", pn, period_nv_bcd)
      `CHK("period_ram", pr, period_ram_bcd)
      `CHK("thresh_nv", tn, thresh_nv_bcd)
      `CHK("thresh_ram", tr, thresh_ram_bcd)
    end
    u_itv_host.send("sx");
    expect_line("s,0000000360c,0000000360f,0000000244t,\r\n");
    u_itv_host.slow = 1;
    u_itv_host.send("S,0000094000;0,245x");
    n = 0;
    while (sim_load !== 1'h1 && n < 50) begin
      @(negedge ref_clk);
      n++;
    end
    `CHK("sim_load", 1'h1, sim_load)
    repeat (8) @(posedge ref_clk);
    `CHK("early bytes", 0, u_itv_host.rxq.size())
    calc_valid <= 1'h1;
    `CHK("sim_count", 40'h94000, sim_count_bcd)
    `CHK("sim_freq", 40'h0, sim_freq_bcd)
    `CHK("sim_temp", 40'h245, sim_temp_adc_bcd)
    expect_line({"S,0000094000c,0000000000f,0000000245t,r, 18.04m,0000000000Hz,",
      "0000094000c,0000000.204s,-029.0C\r\n"});
    complete_run();
  end
endmodule
`default_nettype wire

// [testbench/itv_host.sv]
// partner model: serial relay that sends command bytes and drains replies
`timescale 1ns/10ps
`default_nettype none
module itv_host (
  input wire logic ref_clk,
  input wire logic cts,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic tx_ready
);
  logic [7:0] rxq[$];
  int slow = 0;
  int cyc = 0;
  initial begin
    rx_valid = 1'h0;
    rx_data = 8'h00;
    tx_ready = 1'h0;
  end
  // wait for clear-to-send, then stream a whole command back to back
  task automatic send(input string s);
    @(negedge ref_clk);
    while (cts !== 1'h1) @(negedge ref_clk);
    foreach (s[i]) begin
      @(posedge ref_clk);
      rx_valid <= 1'h1;
      rx_data <= s[i];
    end
    @(posedge ref_clk);
    rx_valid <= 1'h0;
    rx_data <= ~s[s.len()-1];
  endtask
  always @(negedge ref_clk) if (tx_valid && tx_ready) rxq.push_back(tx_data);
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    tx_ready <= (slow == 0) || (cyc % 3 == 0);
  end
endmodule
`default_nettype wire
